/* File: saw_regs.vh */
// Constants for the stored-address wrap logic of the USER memory bank.
// Assumes a 10-bit USER word address and 16-bit data words.
`ifndef SAW_REGS_VH
`define SAW_REGS_VH

// Register locations in the USER bank.
`define ADDR_CTRL_STATUS   10'h002
`define ADDR_WORK_PTR      10'h003
`define ADDR_PRESET_RESET  10'h006
`define ADDR_USER_TOP      11'h400
`define WORDPTR_POINTER    14'h3FFF

// Field positions in the control and status word.
`define BIT_WRAP_EN        0
`define BIT_EOM_LOCK       1
`define BIT_PRESET_UPD     2
`define BIT_PRE_INCR       3
`define BIT_BLK_LO         4
`define BIT_BLK_HI         5
`define BIT_WRAPPED        8
`define BIT_FULL           9
`define CTRL_WR_MASK       16'h003F
`define CTRL_RESET         16'h0030

// Memory bank code of USER.
`define BANK_USER          2'h3

// Command codes of the decoded Gen2 command stream.
`define CMD_SELECT         4'h0
`define CMD_QUERY          4'h1
`define CMD_QUERYADJ       4'h2
`define CMD_QUERYREP       4'h3
`define CMD_ACK            4'h4
`define CMD_NAK            4'h5
`define CMD_REQRN          4'h6
`define CMD_READ           4'h7
`define CMD_WRITE          4'h8
`define CMD_KILL           4'h9
`define CMD_LOCK           4'hA
`define CMD_ACCESS         4'hB
`define CMD_BLOCKWRITE     4'hC
`define CMD_BLOCKPERMALOCK 4'hD

`endif

/* File: last_free_calc.v */
// Works out the last free USER location from the block size selection.
// Assumes the selection is a stable register value.
`timescale 1ns/1ps
module last_free_calc
(
  blockSel,
  lastFree
);
  input  wire [1:0] blockSel;
  output wire [9:0] lastFree;

  wire [10:0] topMinus;

  // Block size is 16 << blockSel words; the top (1 << blockSel) - 1 words
  // are held back, so larger blocks lose more trailing locations.
  assign topMinus = 11'h400 - (11'h001 << blockSel);
  assign lastFree = topMinus[9:0];
endmodule

/* File: stored_address_wrap_logic.v */
// Stored address pointer and wrap handling for the USER memory bank.
// Assumes commands arrive already decoded from the air interface, one per
// cycle at most, and that the USER array sits outside on the memWr port.
//
// Behaviour
// - Preset pointer is held and copied to working pointer on a wrap.
// - Wrap needs wrap enable set, end lock clear, pointer at last free.
// - Last free location follows the configured block size selection.
// - Write to pointer word with preset update flag stores a new preset.
// - With preset update flag set, a write to the pointer word leaves the working pointer unchanged.
// - Wrapping write sets pointer to preset and writes data there.
// - Locations below the preset are never hit by wrapping writes.
// - Preset pointer resets to USER address 0x006.
// - Accept the standard command set, Select through BlockPermalock.
// - With pre-increment select set, pointer advances before each pointer-based write that neither wraps nor is refused.
`timescale 1ns/1ps
`include "saw_regs.vh"
module stored_address_wrap_logic
(
  clk,
  srst,
  cmdValid,
  cmdCode,
  cmdBank,
  cmdWordPtr,
  cmdData,
  rspValid,
  rspError,
  rspData,
  memWrEn,
  memWrAddr,
  memWrData,
  workPtr,
  presetPtr
);
  input  wire        clk;
  input  wire        srst;
  input  wire        cmdValid;
  input  wire [3:0]  cmdCode;
  input  wire [1:0]  cmdBank;
  input  wire [13:0] cmdWordPtr;
  input  wire [15:0] cmdData;
  output reg         rspValid;
  output reg         rspError;
  output reg  [15:0] rspData;
  output reg         memWrEn;
  output reg  [9:0]  memWrAddr;
  output reg  [15:0] memWrData;
  output wire [9:0]  workPtr;
  output wire [9:0]  presetPtr;

  reg  [15:0] ctrl_reg;
  reg  [15:0] ctrl_next;
  reg  [9:0]  work_reg;
  reg  [9:0]  work_next;
  reg  [9:0]  preset_reg;
  reg  [9:0]  preset_next;
  reg         rspValid_next;
  reg         rspError_next;
  reg  [15:0] rspData_next;
  reg         memWrEn_next;
  reg  [9:0]  memWrAddr_next;
  reg  [15:0] memWrData_next;
  reg         known;
  reg         wrapNow;
  reg  [9:0]  target;
  wire [9:0]  lastFree;
  wire        isUser;
  wire        isPointerWrite;
  wire        atLast;

  assign workPtr   = work_reg;
  assign presetPtr = preset_reg;

  // The block size field picks the top of the usable area.
  last_free_calc u_last
  (
    .blockSel (ctrl_reg[`BIT_BLK_HI:`BIT_BLK_LO]),
    .lastFree (lastFree)
  );

  assign isUser         = (cmdBank == `BANK_USER);
  assign isPointerWrite = isUser && (cmdWordPtr == `WORDPTR_POINTER);
  assign atLast         = (work_reg == lastFree);

  // Command support check; anything outside the set is answered as error.
  always @*
  begin
    case (cmdCode)
      `CMD_SELECT, `CMD_QUERY, `CMD_QUERYADJ, `CMD_QUERYREP,
      `CMD_ACK, `CMD_NAK, `CMD_REQRN, `CMD_READ, `CMD_WRITE,
      `CMD_KILL, `CMD_LOCK, `CMD_ACCESS, `CMD_BLOCKWRITE,
      `CMD_BLOCKPERMALOCK:
        known = 1'b1;
      default:
        known = 1'b0;
    endcase
  end

  // Target of a pointer-based write, including the wrap decision.
  always @*
  begin
    wrapNow = ctrl_reg[`BIT_WRAP_EN] && !ctrl_reg[`BIT_EOM_LOCK] &&
              atLast;
    if (wrapNow)
    begin
      target = preset_reg;
    end
    else if (ctrl_reg[`BIT_PRE_INCR])
    begin
      target = work_reg + 10'h001;
    end
    else
    begin
      target = work_reg;
    end
  end

  // Next-state logic for registers, answers and the memory write port.
  always @*
  begin
    ctrl_next      = ctrl_reg;
    work_next      = work_reg;
    preset_next    = preset_reg;
    rspValid_next  = 1'b0;
    rspError_next  = 1'b0;
    rspData_next   = rspData;
    memWrEn_next   = 1'b0;
    memWrAddr_next = memWrAddr;
    memWrData_next = memWrData;
    if (cmdValid)
    begin
      rspValid_next = 1'b1;
      if (!known)
      begin
        rspError_next = 1'b1;
      end
      else if (cmdCode == `CMD_WRITE && isPointerWrite)
      begin
        // At the last free word with no wrap allowed, the write is refused rather
        // than running past the usable area of the USER bank.
        if (atLast && !wrapNow)
        begin
          rspError_next = 1'b1;
          ctrl_next[`BIT_FULL] = 1'b1;
        end
        else
        begin
          work_next      = target;
          memWrEn_next   = 1'b1;
          memWrAddr_next = target;
          memWrData_next = cmdData;
          if (wrapNow)
          begin
            ctrl_next[`BIT_WRAPPED] = 1'b1;
          end
        end
      end
      else if (cmdCode == `CMD_WRITE && isUser &&
               cmdWordPtr[9:0] == `ADDR_CTRL_STATUS &&
               cmdWordPtr[13:10] == 4'h0)
      begin
        ctrl_next = (ctrl_reg & ~`CTRL_WR_MASK) |
                    (cmdData & `CTRL_WR_MASK);
      end
      else if (cmdCode == `CMD_WRITE && isUser &&
               cmdWordPtr[9:0] == `ADDR_WORK_PTR &&
               cmdWordPtr[13:10] == 4'h0)
      begin
        if (ctrl_reg[`BIT_PRESET_UPD])
        begin
          preset_next = cmdData[9:0];
          // Working pointer is left as it was.
        end
        else
        begin
          work_next = cmdData[9:0];
        end
      end
      else if (cmdCode == `CMD_WRITE && isUser)
      begin
        memWrEn_next   = 1'b1;
        memWrAddr_next = cmdWordPtr[9:0];
        memWrData_next = cmdData;
      end
      else if (cmdCode == `CMD_READ && isUser &&
               cmdWordPtr[13:10] == 4'h0)
      begin
        if (cmdWordPtr[9:0] == `ADDR_CTRL_STATUS)
        begin
          rspData_next = ctrl_reg;
        end
        else if (cmdWordPtr[9:0] == `ADDR_WORK_PTR)
        begin
          rspData_next = {6'h00, work_reg};
        end
        else
        begin
          rspData_next = 16'h0000;
        end
      end
    end
  end

  // All state and outputs update here; reset restores factory values.
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_reg   <= `CTRL_RESET;
      work_reg   <= `ADDR_PRESET_RESET;
      preset_reg <= `ADDR_PRESET_RESET;
      rspValid   <= 1'b0;
      rspError   <= 1'b0;
      rspData    <= 16'h0000;
      memWrEn    <= 1'b0;
      memWrAddr  <= 10'h000;
      memWrData  <= 16'h0000;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      work_reg   <= work_next;
      preset_reg <= preset_next;
      rspValid   <= rspValid_next;
      rspError   <= rspError_next;
      rspData    <= rspData_next;
      memWrEn    <= memWrEn_next;
      memWrAddr  <= memWrAddr_next;
      memWrData  <= memWrData_next;
    end
  end
endmodule

/* File: saw_checker.sv */
// Port checker for the stored address wrap logic.
// Assumes a single clk domain and synchronous srst.
`timescale 1ns/1ps
`include "saw_regs.vh"
module saw_checker
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cmdValid,
  input wire logic [3:0]  cmdCode,
  input wire logic [13:0] cmdWordPtr,
  input wire logic [15:0] cmdData,
  input wire logic        rspValid,
  input wire logic        rspError,
  input wire logic        memWrEn,
  input wire logic [9:0]  memWrAddr,
  input wire logic [15:0] memWrData,
  input wire logic [9:0]  workPtr,
  input wire logic [9:0]  presetPtr
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic uwDone;
  logic wkWr;
  // Remember which kind of write was taken one edge ago.
  always_ff @(posedge clk)
  begin
    uwDone <= !srst && cmdValid && cmdCode == `CMD_WRITE
      && cmdWordPtr == `WORDPTR_POINTER;
    wkWr <= !srst && cmdValid && cmdCode == `CMD_WRITE
      && cmdWordPtr == 14'h0003;
  end
  AST_ANSWER: assert property (cmdValid |=> rspValid)
    else $error("command not answered");
  AST_RESET: assert property ($fell(srst) |->
    presetPtr == `ADDR_PRESET_RESET && workPtr == `ADDR_PRESET_RESET)
    else $error("pointers not at reset value");
  AST_PRESET_SRC: assert property (
    $changed(presetPtr) && !$past(srst) |-> wkWr)
    else $error("preset changed without pointer word write");
  AST_PTR_HOLD: assert property (
    $changed(presetPtr) && !$past(srst) |-> $stable(workPtr))
    else $error("working pointer moved with preset");
  AST_WRAP_DATA: assert property (uwDone && memWrEn |->
    memWrAddr == workPtr && memWrData == $past(cmdData))
    else $error("pointer write address or data wrong");
  AST_WRAP_PRESET: assert property (uwDone && memWrEn &&
    memWrAddr < $past(workPtr) |-> memWrAddr == presetPtr)
    else $error("wrap did not land on preset");
  AST_INCR: assert property (uwDone && memWrEn &&
    memWrAddr >= $past(workPtr) |-> memWrAddr <= $past(workPtr) + 10'h001)
    else $error("pointer advanced more than one");
  AST_ERR_NOWR: assert property (rspError |-> !memWrEn)
    else $error("refused command wrote memory");
endmodule

/* File: interrogator_model.sv */
// Interrogator model: sends one decoded command, collects the reply.
// Assumes the tag answers within a few clk cycles.
`timescale 1ns/1ps
`include "saw_regs.vh"
module interrogator_model
(
  input  wire logic        clk,
  input  wire logic        rspValid,
  output logic             cmdValid,
  output logic [3:0]       cmdCode,
  output logic [1:0]       cmdBank,
  output logic [13:0]      cmdWordPtr,
  output logic [15:0]      cmdData
);
  // Idle bus at time zero.
  initial
  begin
    cmdValid = 1'b0;
    cmdCode = 4'h0;
    cmdBank = `BANK_USER;
    cmdWordPtr = 14'h0000;
    cmdData = 16'h0000;
  end
  task automatic send(input logic [3:0] c, input logic [13:0] p,
    input logic [15:0] d, output logic ok);
    int i;
    @(negedge clk);
    cmdValid = 1'b1;
    cmdCode = c;
    cmdWordPtr = p;
    cmdData = d;
    // The answer is registered at the taking edge and stands for one
    // cycle only, so it is looked at on the following falling edge.
    @(negedge clk);
    cmdValid = 1'b0;
    cmdData = ~cmdData; // Released data must not look stable.
    ok = (rspValid === 1'b1);
    for (i = 0; i < 4 && !ok; i++)
    begin
      @(negedge clk);
      ok = (rspValid === 1'b1);
    end
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the stored address wrap logic.
// Assumes saw_regs.vh and the interrogator model are compiled.
`timescale 1ns/1ps
`include "saw_regs.vh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cmdValid, rspValid, rspError, memWrEn, ok;
  logic [3:0] cmdCode;
  logic [1:0] cmdBank;
  logic [13:0] cmdWordPtr;
  logic [15:0] cmdData, rspData, memWrData;
  logic [9:0] memWrAddr, workPtr, presetPtr;
  int errorCnt = 0;
  int compares = 0;
  stored_address_wrap_logic DUT (.clk, .srst, .cmdValid, .cmdCode,
    .cmdBank, .cmdWordPtr, .cmdData, .rspValid, .rspError, .rspData,
    .memWrEn, .memWrAddr, .memWrData, .workPtr, .presetPtr);
  interrogator_model host (.clk, .rspValid, .cmdValid, .cmdCode,
    .cmdBank, .cmdWordPtr, .cmdData);
  // 200 MHz clock.
  initial forever #2.5 clk = ~clk;
  task automatic tally_and_finish;
    if (errorCnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [13:0] p,
    input logic [15:0] d);
    host.send(c, p, d, ok);
    if (!ok)
    begin
      errorCnt++;
      $display("wrong value at %0t: no answer", $time);
      tally_and_finish();
    end
  endtask
  // Pointer-based write that must land at a known word.
  task automatic uw(input logic [15:0] d, input logic [15:0] a);
    cmd(`CMD_WRITE, `WORDPTR_POINTER, d);
    chk(memWrEn, 16'h0001);
    chk(memWrAddr, a);
    chk(memWrData, d);
  endtask
  // Main sequence: reset, preset load, wrap, refusals, block size.
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk) srst = 1'b0;
    chk(presetPtr, 16'h0006);
    cmd(`CMD_READ, 14'h0002, 16'h0000);
    chk(rspData, 16'h0030);
    cmd(`CMD_WRITE, 14'h0002, 16'h0035);
    cmd(`CMD_WRITE, 14'h0003, 16'h000A);
    chk(presetPtr, 16'h000A);
    chk(workPtr, 16'h0006);
    cmd(`CMD_WRITE, 14'h0002, 16'h0039);
    cmd(`CMD_WRITE, 14'h0003, 16'h03F7);
    uw(16'h1234, 16'h03F8);
    uw(16'h5678, 16'h000A);
    chk(workPtr, 16'h000A);
    cmd(`CMD_READ, 14'h0003, 16'h0000);
    chk(rspData, 16'h000A);
    uw(16'h9ABC, 16'h000B);
    // Lock set, then wrap off: the last free word must be refused.
    cmd(`CMD_WRITE, 14'h0002, 16'h003B);
    cmd(`CMD_WRITE, 14'h0003, 16'h03F8);
    cmd(`CMD_WRITE, `WORDPTR_POINTER, 16'h1111);
    chk(rspError, 16'h0001);
    cmd(`CMD_WRITE, 14'h0002, 16'h0038);
    cmd(`CMD_WRITE, `WORDPTR_POINTER, 16'h2222);
    chk(memWrEn, 16'h0000);
    // Smallest block size moves the last free word to 0x3FF.
    cmd(`CMD_WRITE, 14'h0002, 16'h0009);
    uw(16'h3333, 16'h03F9);
    cmd(`CMD_WRITE, 14'h0003, 16'h03FF);
    uw(16'h4444, 16'h000A);
    // Sticky wrapped and full bits stand until a mid-run reset clears them.
    cmd(`CMD_READ, 14'h0002, 16'h0000);
    chk(rspData, 16'h0309);
    @(negedge clk) srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk(presetPtr, 16'h0006);
    chk(workPtr, 16'h0006);
    cmd(`CMD_READ, 14'h0002, 16'h0000);
    chk(rspData, 16'h0030);
    for (int c = 0; c < 16; c++)
    begin
      cmd(c[3:0], 14'h0010, 16'h0000);
      chk(rspError, (c >= 14) ? 16'h0001 : 16'h0000);
    end
    tally_and_finish();
  end
endmodule
bind stored_address_wrap_logic saw_checker chk (.clk, .srst, .cmdValid,
  .cmdCode, .cmdWordPtr, .cmdData, .rspValid, .rspError, .memWrEn,
  .memWrAddr, .memWrData, .workPtr, .presetPtr);
